// >>> rtl/wave_seq_pkg.sv
package wave_seq_pkg;

  // Register offsets on the host register port
  localparam logic [7:0] OFF_CTRL = 8'h0c;
  localparam logic [7:0] OFF_SLOT_FIRST = 8'h0f;
  localparam logic [7:0] OFF_SLOT_LAST = 8'h16;
  localparam logic [7:0] OFF_SLOT_THREE = 8'h11;
  localparam logic [7:0] OFF_SLOT_FOUR = 8'h12;

  // Field positions
  localparam int unsigned CTRL_GO_BIT = 0;
  localparam int unsigned SLOT_FLAG_BIT = 7;
  localparam int unsigned SLOT_VAL_MSB = 6;

  // Reset values
  localparam logic [7:0] SLOT_RESET = 8'h00;
  localparam logic [7:0] RDATA_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // Sequencer geometry
  localparam int unsigned SLOT_COUNT = 8;
  localparam logic [2:0] SLOT_IDX_FIRST = 3'h0;
  localparam logic [2:0] SLOT_IDX_LAST = 3'h7;

  // Timing: one idle unit and its length in clock cycles
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned IDLE_UNIT_MS = 10;
  localparam int unsigned IDLE_UNIT_CYCLES = (CLK_HZ / 1000) * IDLE_UNIT_MS;
  localparam int unsigned TICK_CNT_W = 17;

  typedef logic [TICK_CNT_W-1:0] tick_cnt_t;
  typedef logic [7:0] slot_t;
  typedef logic [SLOT_COUNT-1:0][7:0] slot_array_t;

  typedef enum logic [3:0] {
    SEQ_IDLE = 4'b0001,
    SEQ_FETCH = 4'b0010,
    SEQ_PLAY = 4'b0100,
    SEQ_WAIT = 4'b1000
  } seq_state_t;

endpackage

// >>> rtl/slot_regs.sv
`timescale 1ns/1ps
module slot_regs (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Register write port
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  // Stored slots, index 0 at the first slot offset
  output wave_seq_pkg::slot_array_t slots_o
);

  typedef struct packed {
    wave_seq_pkg::slot_array_t slots;
  } regs_state_t;

  regs_state_t s_q;
  regs_state_t s_d;
  logic [wave_seq_pkg::SLOT_COUNT-1:0] hit;

  genvar g;
  generate
    for (g = 0; g < wave_seq_pkg::SLOT_COUNT; g++) begin : g_hit
      assign hit[g] = wr_i && (addr_i == wave_seq_pkg::OFF_SLOT_FIRST + 8'(g));
    end
  endgenerate

  always_comb begin
    s_d = s_q;
    for (int i = 0; i < wave_seq_pkg::SLOT_COUNT; i++) begin
      if (hit[i]) begin
        s_d.slots[i] = wdata_i;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      s_q <= {wave_seq_pkg::SLOT_COUNT{wave_seq_pkg::SLOT_RESET}};
    end else begin
      s_q <= s_d;
    end
  end

  assign slots_o = s_q.slots;

endmodule // slot_regs

// >>> rtl/idle_timer.sv
`timescale 1ns/1ps
module idle_timer #(
  parameter int unsigned UNIT_CYCLES = wave_seq_pkg::IDLE_UNIT_CYCLES
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Control from the sequencer
  input wire logic load_i,
  input wire logic [6:0] units_i,
  input wire logic abort_i,
  // Status
  output logic done_o,
  output logic busy_o
);

  localparam wave_seq_pkg::tick_cnt_t DIV_LAST = wave_seq_pkg::tick_cnt_t'(UNIT_CYCLES - 1);

  typedef struct packed {
    logic busy;
    logic done;
    logic [6:0] units;
    wave_seq_pkg::tick_cnt_t div;
  } timer_state_t;

  timer_state_t s_q;
  timer_state_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    if (abort_i) begin
      s_d.busy = 1'b0;
    end else if (load_i) begin
      // A zero count never reaches here: the sequencer ends on it
      s_d.busy = 1'b1;
      s_d.units = units_i;
      s_d.div = '0;
    end else if (s_q.busy) begin
      if (s_q.div == DIV_LAST) begin
        s_d.div = '0;
        s_d.units = s_q.units - 7'h01; // [RULE9]
        if (s_q.units == 7'h01) begin
          s_d.busy = 1'b0;
          s_d.done = 1'b1;
        end
      end else begin
        s_d.div = s_q.div + wave_seq_pkg::tick_cnt_t'(1);
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign done_o = s_q.done;
  assign busy_o = s_q.busy;

endmodule // idle_timer

// >>> rtl/wave_seq_slots.sv
// Contract
// [RULE1] Delay flag set: idle the engine for value times 10 ms, then advance.
// [RULE2] Timed idle slots form pauses between waveforms played in sequence.
// [RULE3] Delay flag clear: bits 6..0 are a waveform identifier to play.
// [RULE4] The identifier is the library index handed to the playback engine.
// [RULE5] Setting the start bit at 0x0C begins sequencing at slot 0x0F.
// [RULE6] When a slot finishes, advance to the next; play only non-zero ones.
// [RULE7] End at the first zero identifier or after all eight slots.
// [RULE8] A zero identifier is a stop marker and is not played.
// [RULE9] Idle time is the seven-bit value times a fixed 10 ms unit.
// [RULE10] Seven-bit value zero ends the sequence whatever the flag, engine idles.
`timescale 1ns/1ps
module wave_seq_slots #(
  parameter int unsigned IDLE_UNIT_CYCLES = wave_seq_pkg::IDLE_UNIT_CYCLES
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Host register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // Playback engine handshake
  output logic wave_start_o,
  output logic [6:0] wave_id_o,
  output logic wave_stop_o,
  input wire logic wave_done_i,
  // Sequencer status
  output logic seq_busy_o,
  output logic [2:0] seq_slot_o,
  output logic seq_idle_wait_o,
  output logic seq_end_o
);

  typedef struct packed {
    wave_seq_pkg::seq_state_t st;
    logic go;
    logic [2:0] idx;
    logic [6:0] wave_id;
    logic wave_start;
    logic wave_stop;
    logic seq_end;
    logic [7:0] rdata;
  } top_state_t;

  top_state_t s_q;
  top_state_t s_d;

  wave_seq_pkg::slot_array_t slots;
  wave_seq_pkg::slot_t cur_slot;
  logic [6:0] cur_val;
  logic cur_flag;
  logic ctrl_wr;
  logic go_set;
  logic go_clr;
  logic timer_load;
  logic timer_abort;
  logic timer_done;
  logic timer_busy;
  logic advance;
  logic finish;
  logic [7:0] rd_val;

  slot_regs u_slot_regs (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .addr_i(reg_addr_i),
    .wdata_i(reg_wdata_i),
    .wr_i(reg_wr_i),
    .slots_o(slots)
  );

  idle_timer #(
    .UNIT_CYCLES(IDLE_UNIT_CYCLES)
  ) u_idle_timer (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .load_i(timer_load),
    .units_i(cur_val),
    .abort_i(timer_abort),
    .done_o(timer_done),
    .busy_o(timer_busy)
  );

  // Slot under the sequencer; writes to it take effect at the next fetch
  assign cur_slot = slots[s_q.idx];
  assign cur_val = cur_slot[wave_seq_pkg::SLOT_VAL_MSB:0];
  assign cur_flag = cur_slot[wave_seq_pkg::SLOT_FLAG_BIT];

  assign ctrl_wr = reg_wr_i && (reg_addr_i == wave_seq_pkg::OFF_CTRL);
  assign go_set = ctrl_wr && reg_wdata_i[wave_seq_pkg::CTRL_GO_BIT];
  assign go_clr = ctrl_wr && !reg_wdata_i[wave_seq_pkg::CTRL_GO_BIT];

  // Read mux: unmapped offsets read as zero
  always_comb begin
    rd_val = wave_seq_pkg::UNMAPPED_READ;
    if (reg_addr_i == wave_seq_pkg::OFF_CTRL) begin
      rd_val = 8'h00;
      rd_val[wave_seq_pkg::CTRL_GO_BIT] = s_q.go;
    end else if ((reg_addr_i >= wave_seq_pkg::OFF_SLOT_FIRST) &&
                 (reg_addr_i <= wave_seq_pkg::OFF_SLOT_LAST)) begin
      rd_val = slots[3'(reg_addr_i - wave_seq_pkg::OFF_SLOT_FIRST)];
    end
  end

  always_comb begin
    s_d = s_q;
    s_d.wave_start = 1'b0;
    s_d.wave_stop = 1'b0;
    s_d.seq_end = 1'b0;
    timer_load = 1'b0;
    timer_abort = 1'b0;
    advance = 1'b0;
    finish = 1'b0;

    if (reg_rd_i) begin
      s_d.rdata = rd_val;
    end

    unique case (s_q.st)
      wave_seq_pkg::SEQ_IDLE: begin
        if (go_set) begin
          s_d.go = 1'b1;
          s_d.idx = wave_seq_pkg::SLOT_IDX_FIRST; // [RULE5]
          s_d.st = wave_seq_pkg::SEQ_FETCH;
        end
      end
      wave_seq_pkg::SEQ_FETCH: begin
        if (cur_val == 7'h00) begin
          // Stop marker, regardless of the delay flag, is never played
          finish = 1'b1; // [RULE8] [RULE10] [RULE7]
        end else if (cur_flag) begin
          timer_load = 1'b1; // [RULE1] [RULE2]
          s_d.st = wave_seq_pkg::SEQ_WAIT;
        end else begin
          s_d.wave_id = cur_val; // [RULE3] [RULE4]
          s_d.wave_start = 1'b1;
          s_d.st = wave_seq_pkg::SEQ_PLAY;
        end
      end
      wave_seq_pkg::SEQ_PLAY: begin
        if (wave_done_i) begin
          advance = 1'b1; // [RULE6]
        end
      end
      wave_seq_pkg::SEQ_WAIT: begin
        if (timer_done) begin
          advance = 1'b1; // [RULE1]
        end
      end
    endcase

    if (advance) begin
      if (s_q.idx == wave_seq_pkg::SLOT_IDX_LAST) begin
        finish = 1'b1; // [RULE7]
      end else begin
        s_d.idx = s_q.idx + 3'h1; // [RULE6]
        s_d.st = wave_seq_pkg::SEQ_FETCH;
      end
    end

    // Software abort: clearing the start bit while busy stops at once
    if ((s_q.st != wave_seq_pkg::SEQ_IDLE) && go_clr) begin
      s_d.go = 1'b0;
      s_d.st = wave_seq_pkg::SEQ_IDLE;
      s_d.wave_start = 1'b0;
      s_d.wave_stop = (s_q.st == wave_seq_pkg::SEQ_PLAY) || s_q.wave_start;
      timer_abort = 1'b1;
      timer_load = 1'b0;
    end else if (finish) begin
      s_d.seq_end = 1'b1;
      if (go_set) begin
        // A start written in the ending cycle wins over the clear
        s_d.go = 1'b1;
        s_d.idx = wave_seq_pkg::SLOT_IDX_FIRST; // [RULE5]
        s_d.st = wave_seq_pkg::SEQ_FETCH;
      end else begin
        s_d.go = 1'b0;
        s_d.st = wave_seq_pkg::SEQ_IDLE; // [RULE10]
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      s_q.st <= wave_seq_pkg::SEQ_IDLE;
      s_q.go <= 1'b0;
      s_q.idx <= wave_seq_pkg::SLOT_IDX_FIRST;
      s_q.wave_id <= 7'h00;
      s_q.wave_start <= 1'b0;
      s_q.wave_stop <= 1'b0;
      s_q.seq_end <= 1'b0;
      s_q.rdata <= wave_seq_pkg::RDATA_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata_o = s_q.rdata;
  assign wave_start_o = s_q.wave_start;
  assign wave_id_o = s_q.wave_id;
  assign wave_stop_o = s_q.wave_stop;
  assign seq_busy_o = s_q.go;
  assign seq_slot_o = s_q.idx;
  // Engine is held idle during a timed slot
  assign seq_idle_wait_o = timer_busy; // [RULE2]
  assign seq_end_o = s_q.seq_end;

endmodule // wave_seq_slots

// >>> tb/wave_seq_slots_chk.sv
`timescale 1ns/1ps
module wave_seq_slots_chk #(
  parameter int unsigned IDLE_UNIT_CYCLES = 4
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Host register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  // Playback engine handshake
  input wire logic wave_start_o,
  input wire logic [6:0] wave_id_o,
  input wire logic wave_stop_o,
  input wire logic wave_done_i,
  // Sequencer status
  input wire logic seq_busy_o,
  input wire logic [2:0] seq_slot_o,
  input wire logic seq_idle_wait_o,
  input wire logic seq_end_o
);
  logic [23:0] run_q;
  // Wide enough for the longest idle slot at the full unit length
  always_ff @(posedge mclk_i) begin
    if (rst_i || !seq_idle_wait_o) begin
      run_q <= '0;
    end else begin
      run_q <= run_q + 24'h1;
    end
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  property p_go_starts;
    reg_wr_i && reg_addr_i == wave_seq_pkg::OFF_CTRL &&
      reg_wdata_i[wave_seq_pkg::CTRL_GO_BIT] && !seq_busy_o
      |=> seq_busy_o && seq_slot_o == 3'h0;
  endproperty
  a_go_starts: assert property (p_go_starts) else $error("start did not begin at slot 0");
  property p_first_action;
    $rose(seq_busy_o) |-> ##[1:3] (wave_start_o || seq_idle_wait_o || seq_end_o);
  endproperty
  a_first_action: assert property (p_first_action) else $error("no action on first slot");
  property p_id_nonzero;
    wave_start_o |-> wave_id_o != 7'h00 && seq_busy_o;
  endproperty
  a_id_nonzero: assert property (p_id_nonzero) else $error("zero id was played");
  property p_wait_excl;
    seq_idle_wait_o |-> !wave_start_o && seq_busy_o;
  endproperty
  a_wait_excl: assert property (p_wait_excl) else $error("waveform started in idle slot");
  property p_idle_units;
    $fell(seq_idle_wait_o) && seq_busy_o |-> run_q != 24'h0 && run_q % IDLE_UNIT_CYCLES == 0;
  endproperty
  a_idle_units: assert property (p_idle_units) else $error("idle not whole units");
  property p_advance;
    seq_busy_o && $past(seq_busy_o) && seq_slot_o != $past(seq_slot_o)
      |-> seq_slot_o == $past(seq_slot_o) + 3'h1 || (seq_end_o && seq_slot_o == 3'h0);
  endproperty
  a_advance: assert property (p_advance) else $error("slot skipped");
  property p_end;
    // A start written in the ending cycle restarts at slot 0 with busy kept high
    seq_end_o |-> (!seq_busy_o || seq_slot_o == 3'h0) && !wave_start_o && !seq_idle_wait_o
      ##1 !seq_end_o;
  endproperty
  a_end: assert property (p_end) else $error("bad sequence end");
  property p_id_hold;
    !wave_start_o |-> $stable(wave_id_o);
  endproperty
  a_id_hold: assert property (p_id_hold) else $error("id changed without start");
endmodule // wave_seq_slots_chk

bind wave_seq_slots wave_seq_slots_chk #(.IDLE_UNIT_CYCLES(IDLE_UNIT_CYCLES)) u_wave_seq_slots_chk (
  .mclk_i(mclk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .wave_start_o(wave_start_o), .wave_id_o(wave_id_o), .wave_stop_o(wave_stop_o),
  .wave_done_i(wave_done_i), .seq_busy_o(seq_busy_o), .seq_slot_o(seq_slot_o),
  .seq_idle_wait_o(seq_idle_wait_o), .seq_end_o(seq_end_o)
);

// >>> tb/wave_seq_slots_tb.sv
`timescale 1ns/1ps
module wave_seq_slots_tb;
  localparam int unsigned UNIT = 4;
  logic mclk_i, rst_i, reg_wr_i, reg_rd_i, wave_done_i;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
  logic wave_start_o, wave_stop_o, seq_busy_o, seq_idle_wait_o, seq_end_o;
  logic [6:0] wave_id_o;
  logic [2:0] seq_slot_o;
  int fails = 0;
  int compares = 0;
  wave_seq_slots #(.IDLE_UNIT_CYCLES(UNIT)) u_wave_seq_slots (
    .mclk_i(mclk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .wave_start_o(wave_start_o), .wave_id_o(wave_id_o), .wave_stop_o(wave_stop_o),
    .wave_done_i(wave_done_i), .seq_busy_o(seq_busy_o), .seq_slot_o(seq_slot_o),
    .seq_idle_wait_o(seq_idle_wait_o), .seq_end_o(seq_end_o)
  );
  initial begin
    mclk_i = 1'b0;
    forever #50 mclk_i = ~mclk_i;
  end
  task chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    @(negedge mclk_i);
    chk(reg_rdata_o, exp);
  endtask
  // Waits for a start, checks it, then answers with one done pulse
  task play(input logic [6:0] id, input logic [2:0] slot);
    int n;
    n = 0;
    while (wave_start_o !== 1'b1 && n < 60) begin
      @(negedge mclk_i);
      n++;
    end
    chk({7'h0, wave_start_o}, 8'h01);
    chk({1'b0, wave_id_o}, {1'b0, id});
    chk({5'h0, seq_slot_o}, {5'h0, slot});
    @(posedge mclk_i);
    wave_done_i <= 1'b1;
    @(posedge mclk_i);
    wave_done_i <= 1'b0;
  endtask
  task idle(input int units);
    int n;
    n = 0;
    while (seq_idle_wait_o !== 1'b1 && n < 60) begin
      @(negedge mclk_i);
      n++;
    end
    n = 0;
    while (seq_idle_wait_o === 1'b1 && n < 1000) begin
      @(negedge mclk_i);
      n++;
    end
    chk(8'(n), 8'(units * UNIT));
  endtask
  // Ends at the end pulse or after 60 cycles without it; any start seen meanwhile is an error
  task fin();
    int n;
    n = 0;
    while (seq_end_o !== 1'b1 && n < 60) begin
      @(negedge mclk_i);
      if (wave_start_o === 1'b1) chk(8'h01, 8'h00);
      n++;
    end
    chk({7'h0, seq_end_o}, 8'h01);
    chk({7'h0, seq_busy_o}, 8'h00);
  endtask
  task conclude();
    $display("checks %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge mclk_i);
    fails++;
    conclude();
  end
  initial begin
    rst_i = 1'b1;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    reg_addr_i = 8'h00;
    reg_wdata_i = 8'h00;
    wave_done_i = 1'b0;
    repeat (3) @(posedge mclk_i);
    rst_i <= 1'b0;
    rd(8'h11, 8'h00);
    rd(8'h12, 8'h00);
    wr(8'h11, 8'h85);
    wr(8'h12, 8'h7f);
    rd(8'h11, 8'h85);
    rd(8'h12, 8'h7f);
    rd(8'h20, 8'h00);
    // All eight slots hold waveforms: the sequence stops after the last
    for (int i = 0; i < 8; i++) wr(8'h0f + 8'(i), 8'(i + 1));
    wr(8'h0c, 8'h01);
    for (int i = 0; i < 8; i++) play(7'(i + 1), 3'(i));
    fin();
    // Waveform, two-unit pause, waveform, then a stop marker
    wr(8'h0f, 8'h05);
    wr(8'h10, 8'h82);
    wr(8'h11, 8'h2a);
    wr(8'h12, 8'h00);
    wr(8'h0c, 8'h01);
    play(7'h05, 3'h0);
    idle(2);
    play(7'h2a, 3'h2);
    fin();
    // Flag set with value zero still terminates
    wr(8'h0f, 8'h01);
    wr(8'h10, 8'h81);
    wr(8'h11, 8'h80);
    wr(8'h0c, 8'h01);
    play(7'h01, 3'h0);
    idle(1);
    fin();
    // Clearing the start bit mid-waveform aborts with a stop pulse and no end pulse
    wr(8'h0f, 8'h03);
    wr(8'h0c, 8'h01);
    rd(8'h0c, 8'h01);
    chk({1'b0, wave_id_o}, 8'h03);
    wr(8'h0c, 8'h00);
    @(negedge mclk_i);
    chk({7'h0, wave_stop_o}, 8'h01);
    chk({7'h0, seq_busy_o}, 8'h00);
    chk({7'h0, seq_end_o}, 8'h00);
    rd(8'h0c, 8'h00);
    conclude();
  end
endmodule // wave_seq_slots_tb
